// *** src/scu_map.svh ***
// Purpose: Offsets, field positions and counts of the system unit
// Assumes: Included by the system unit design files
// Notes: Definitions only
`ifndef SCU_MAP_SVH
`define SCU_MAP_SVH
// Control register numbers
`define SCU_CR_INDEX 5'h00
`define SCU_CR_RANDOM 5'h01
`define SCU_CR_ENTRY_LO 5'h02
`define SCU_CR_ENTRY_HI 5'h0A
`define SCU_CR_STATUS 5'h0C
`define SCU_CR_EPC 5'h0E
`define SCU_CR_ERR_EPC 5'h1E
// Status and index field positions
`define SCU_ST_ERL 2
`define SCU_ST_EXL 1
`define SCU_IDX_MISS 31
// Reset values and counts
`define SCU_STATUS_RST 32'h00000000
`define SCU_FLUSH_CYCLES 256
`define SCU_TLB_DEPTH 32
`endif

// *** src/scu_pkg.sv ***
// Purpose: Types shared by the system unit design files
// Assumes: Nothing
// Notes: All state structs are packed
package scu_pkg;

    typedef enum logic [4:0] {
        OP_NONE, OP_COPROC, OP_BC_T, OP_BC_TL, OP_BC_F, OP_BC_FL,
        OP_MTC, OP_MFC, OP_TRANSLATION_READ_INDEXED, OP_TRANSLATION_WRITE_INDEXED, OP_TRANSLATION_WRITE_RANDOM, OP_TRANSLATION_PROBE,
        OP_EXCEPTION_RETURN_OP, OP_RFE, OP_WAIT, OP_FLI, OP_FLD, OP_FLID, OP_WB
    } scu_op_t;

    typedef enum logic [2:0] {
        PH_IDLE, PH_READ, PH_PROBE, PH_FLUSH, PH_WAIT
    } scu_phase_t;

    typedef struct packed {
        scu_op_t op;
        logic [1:0] cop_sel;
        logic [4:0] rd;
        logic [15:0] offset;
        logic [24:0] cofun;
        logic [31:0] slot_pc;
        logic [31:0] rt_data;
        logic [31:0] base_data;
    } scu_instr_t;

    typedef struct packed {
        logic taken;
        logic squash;
        logic [31:0] target;
    } scu_redirect_t;

    typedef struct packed {
        logic busy;
        logic [15:0] cnt;
    } scu_timer_st_t;

    typedef struct packed {
        scu_phase_t phase;
        logic [1:0] int_sync;
        logic [1:0] nmi_sync;
        logic [31:0] index;
        logic [31:0] random;
        logic [31:0] entry_hi;
        logic [31:0] entry_lo;
        logic [31:0] status;
        logic [31:0] exception_return_pc;
        logic [31:0] err_epc;
        logic [7:0] scan;
        logic cmp_vld;
        logic [7:0] cmp_addr;
        logic stall;
        scu_redirect_t redirect;
        logic pc_load;
        logic [31:0] pc_value;
        logic cop_fwd;
        logic [1:0] cop_sel;
        logic [24:0] cop_fun;
        logic gpr_we;
        logic [31:0] gpr_data;
        logic resv_exc;
        logic icache_inv;
        logic dcache_inv;
        logic wb_req;
        logic [31:0] wb_addr;
    } scu_top_st_t;

endpackage

// *** src/scu_tlb_mem.sv ***
// Purpose: Translation entry storage with registered read data
// Assumes: One write port and one read port on one clock
// Notes: Read data appear one cycle after the address
module scu_tlb_mem
    import scu_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int W = 64
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule // scu_tlb_mem

// *** src/scu_stall_timer.sv ***
// Purpose: Fixed-length stall counter for cache flushes
// Assumes: Start is a one-cycle pulse while idle
// Notes: Busy stands for CYCLES cycles after the start
module scu_stall_timer
    import scu_pkg::*;
#(
    parameter int CYCLES = 256
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    localparam logic [15:0] LAST = 16'(CYCLES - 1);
    scu_timer_st_t st_r;
    scu_timer_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (i_start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = '0;
        end else if (st_r.busy) begin
            if (st_r.cnt == LAST) begin
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_busy = st_r.busy;
    assign o_done = st_r.busy && (st_r.cnt == LAST);
endmodule // scu_stall_timer

// *** src/scu_sysctl_unit.sv ***
// Purpose: Coprocessor, translation, return, wait and cache instructions
// Assumes: Pipeline holds its request while o_stall is high
// Notes: All outputs come from the state register
`include "scu_map.svh"

////////////////////////////////////////////////////////////////////////
// How it works
// - Coprocessor operation forwarded, processor state untouched
// - Branch on coprocessor condition true or false
// - Target is delay-slot address plus shifted offset
// - Branch takes effect after one delay slot
// - Likely branch not taken squashes delay slot
// - Move general register into control register
// - Move control register into general register
// - Indexed read fills entry high and low
// - Indexed write stores entry high and low
// - Random write stores at random register entry
// - Probe loads index, sets top bit on miss
// - Newer return picks error or normal PC
// - Older restore shifts status mode bit stack
// - Wrong return form raises reserved exception
// - Wait stalls until interrupt, nmi or reset
// - Flushes invalidate caches, stall 256 cycles
// - Writeback line at base plus offset
module scu_sysctl_unit
    import scu_pkg::*;
#(
    parameter int TLB_DEPTH = `SCU_TLB_DEPTH,
    parameter int FLUSH_CYCLES = `SCU_FLUSH_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire scu_instr_t i_instr,
    input wire logic [3:0] i_cop_cond,
    input wire logic i_compat_mode,
    input wire logic i_hw_int,
    input wire logic i_nmi,
    output logic o_stall,
    output scu_redirect_t o_redirect,
    output logic o_pc_load,
    output logic [31:0] o_pc_value,
    output logic o_cop_fwd,
    output logic [1:0] o_cop_sel,
    output logic [24:0] o_cop_fun,
    output logic o_gpr_we,
    output logic [31:0] o_gpr_data,
    output logic o_resv_exc,
    output logic o_icache_inv,
    output logic o_dcache_inv,
    output logic o_wb_req,
    output logic [31:0] o_wb_addr,
    output logic [31:0] o_status
);
    localparam int AW = $clog2(TLB_DEPTH);
    localparam logic [7:0] SCAN_LAST = 8'(TLB_DEPTH - 1);
    localparam logic [31:0] RAND_TOP = 32'(TLB_DEPTH - 1);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] branch_disp(input logic [15:0] off);
        branch_disp = {{14{off[15]}}, off, 2'b00};
    endfunction

    function automatic logic [31:0] sext16(input logic [15:0] off);
        sext16 = {{16{off[15]}}, off};
    endfunction

    function automatic logic [31:0] ctl_read(input scu_top_st_t s,
                                             input logic [4:0] sel);
        case (sel)
            `SCU_CR_INDEX: ctl_read = s.index;
            `SCU_CR_RANDOM: ctl_read = s.random;
            `SCU_CR_ENTRY_LO: ctl_read = s.entry_lo;
            `SCU_CR_ENTRY_HI: ctl_read = s.entry_hi;
            `SCU_CR_STATUS: ctl_read = s.status;
            `SCU_CR_EPC: ctl_read = s.exception_return_pc;
            `SCU_CR_ERR_EPC: ctl_read = s.err_epc;
            default: ctl_read = 32'h00000000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State and submodules

    scu_top_st_t st_r;
    scu_top_st_t st_nxt;
    logic acc;
    logic cond_now;
    logic tlb_we;
    logic [AW-1:0] tlb_waddr;
    logic [AW-1:0] tlb_raddr;
    logic [63:0] tlb_rdata;
    logic flush_start;
    logic flush_done;

    assign acc = i_valid && (st_r.phase == PH_IDLE);
    assign cond_now = i_cop_cond[i_instr.cop_sel];

    scu_tlb_mem #(
        .DEPTH(TLB_DEPTH),
        .AW(AW),
        .W(64)
    ) u_tlb (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(tlb_we),
        .i_waddr(tlb_waddr),
        .i_wdata({st_r.entry_hi, st_r.entry_lo}),
        .i_raddr(tlb_raddr),
        .o_rdata(tlb_rdata)
    );

    scu_stall_timer #(
        .CYCLES(FLUSH_CYCLES)
    ) u_flush_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(flush_start),
        .o_busy(),
        .o_done(flush_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Translation memory control

    always_comb begin
        tlb_we = acc && (i_instr.op == OP_TRANSLATION_WRITE_INDEXED || i_instr.op == OP_TRANSLATION_WRITE_RANDOM);
        if (i_instr.op == OP_TRANSLATION_WRITE_RANDOM) begin
            tlb_waddr = st_r.random[AW-1:0];
        end else begin
            tlb_waddr = st_r.index[AW-1:0];
        end
        if (st_r.phase == PH_PROBE) begin
            tlb_raddr = st_r.scan[AW-1:0];
        end else begin
            tlb_raddr = st_r.index[AW-1:0];
        end
        flush_start = acc && (i_instr.op == OP_FLI ||
            i_instr.op == OP_FLD || i_instr.op == OP_FLID);
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.int_sync = {st_r.int_sync[0], i_hw_int};
        st_nxt.nmi_sync = {st_r.nmi_sync[0], i_nmi};
        st_nxt.redirect.taken = 1'b0;
        st_nxt.redirect.squash = 1'b0;
        st_nxt.pc_load = 1'b0;
        st_nxt.cop_fwd = 1'b0;
        st_nxt.gpr_we = 1'b0;
        st_nxt.resv_exc = 1'b0;
        st_nxt.icache_inv = 1'b0;
        st_nxt.dcache_inv = 1'b0;
        st_nxt.wb_req = 1'b0;
        st_nxt.cmp_vld = 1'b0;
        if (st_r.random == 32'h00000000) begin
            st_nxt.random = RAND_TOP;
        end else begin
            st_nxt.random = st_r.random - 32'h00000001;
        end
        case (st_r.phase)
            PH_IDLE: begin
                if (acc) begin
                    case (i_instr.op)
                        OP_COPROC: begin
                            st_nxt.cop_fwd = 1'b1;
                            st_nxt.cop_sel = i_instr.cop_sel;
                            st_nxt.cop_fun = i_instr.cofun;
                        end
                        OP_BC_T, OP_BC_TL, OP_BC_F, OP_BC_FL: begin
                            st_nxt.redirect.target = i_instr.slot_pc +
                                branch_disp(i_instr.offset);
                            if ((i_instr.op == OP_BC_T ||
                                 i_instr.op == OP_BC_TL) == cond_now) begin
                                st_nxt.redirect.taken = 1'b1;
                            end else if (i_instr.op == OP_BC_TL ||
                                         i_instr.op == OP_BC_FL) begin
                                st_nxt.redirect.squash = 1'b1;
                            end
                        end
                        OP_MTC: begin
                            case (i_instr.rd)
                                `SCU_CR_INDEX: st_nxt.index = i_instr.rt_data;
                                `SCU_CR_ENTRY_LO:
                                    st_nxt.entry_lo = i_instr.rt_data;
                                `SCU_CR_ENTRY_HI:
                                    st_nxt.entry_hi = i_instr.rt_data;
                                `SCU_CR_STATUS:
                                    st_nxt.status = i_instr.rt_data;
                                `SCU_CR_EPC: st_nxt.exception_return_pc = i_instr.rt_data;
                                `SCU_CR_ERR_EPC:
                                    st_nxt.err_epc = i_instr.rt_data;
                                default: ;
                            endcase
                        end
                        OP_MFC: begin
                            st_nxt.gpr_we = 1'b1;
                            st_nxt.gpr_data = ctl_read(st_r, i_instr.rd);
                        end
                        OP_TRANSLATION_READ_INDEXED: st_nxt.phase = PH_READ;
                        OP_TRANSLATION_PROBE: begin
                            st_nxt.phase = PH_PROBE;
                            st_nxt.scan = 8'h00;
                        end
                        OP_EXCEPTION_RETURN_OP: begin
                            if (i_compat_mode) begin
                                st_nxt.resv_exc = 1'b1;
                            end else if (st_r.status[`SCU_ST_ERL]) begin
                                st_nxt.pc_load = 1'b1;
                                st_nxt.pc_value = st_r.err_epc;
                                st_nxt.status[`SCU_ST_ERL] = 1'b0;
                            end else begin
                                st_nxt.pc_load = 1'b1;
                                st_nxt.pc_value = st_r.exception_return_pc;
                                st_nxt.status[`SCU_ST_EXL] = 1'b0;
                            end
                        end
                        OP_RFE: begin
                            if (!i_compat_mode) begin
                                st_nxt.resv_exc = 1'b1;
                            end else begin
                                st_nxt.status[3:0] =
                                    st_r.status[5:2];
                            end
                        end
                        OP_WAIT: st_nxt.phase = PH_WAIT;
                        OP_FLI, OP_FLD, OP_FLID: begin
                            st_nxt.phase = PH_FLUSH;
                            st_nxt.icache_inv = (i_instr.op != OP_FLD);
                            st_nxt.dcache_inv = (i_instr.op != OP_FLI);
                        end
                        OP_WB: begin
                            st_nxt.wb_req = 1'b1;
                            st_nxt.wb_addr = i_instr.base_data +
                                sext16(i_instr.offset);
                        end
                        default: ;
                    endcase
                end
            end
            PH_READ: begin
                st_nxt.entry_hi = tlb_rdata[63:32];
                st_nxt.entry_lo = tlb_rdata[31:0];
                st_nxt.phase = PH_IDLE;
            end
            PH_PROBE: begin
                st_nxt.cmp_vld = 1'b1;
                st_nxt.cmp_addr = st_r.scan;
                st_nxt.scan = st_r.scan + 8'h01;
                if (st_r.cmp_vld && tlb_rdata ==
                    {st_r.entry_hi, st_r.entry_lo}) begin
                    st_nxt.index = {24'h000000, st_r.cmp_addr};
                    st_nxt.phase = PH_IDLE;
                    st_nxt.cmp_vld = 1'b0;
                end else if (st_r.cmp_vld &&
                             st_r.cmp_addr == SCAN_LAST) begin
                    st_nxt.index[`SCU_IDX_MISS] = 1'b1;
                    st_nxt.phase = PH_IDLE;
                    st_nxt.cmp_vld = 1'b0;
                end
            end
            PH_FLUSH: begin
                if (flush_done) begin
                    st_nxt.phase = PH_IDLE;
                end
            end
            PH_WAIT: begin
                if (st_r.int_sync[1] || st_r.nmi_sync[1]) begin
                    st_nxt.phase = PH_IDLE;
                end
            end
            default: st_nxt.phase = PH_IDLE;
        endcase
        st_nxt.stall = (st_nxt.phase != PH_IDLE);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
            st_r.status <= `SCU_STATUS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_stall = st_r.stall;
    assign o_redirect = st_r.redirect;
    assign o_pc_load = st_r.pc_load;
    assign o_pc_value = st_r.pc_value;
    assign o_cop_fwd = st_r.cop_fwd;
    assign o_cop_sel = st_r.cop_sel;
    assign o_cop_fun = st_r.cop_fun;
    assign o_gpr_we = st_r.gpr_we;
    assign o_gpr_data = st_r.gpr_data;
    assign o_resv_exc = st_r.resv_exc;
    assign o_icache_inv = st_r.icache_inv;
    assign o_dcache_inv = st_r.dcache_inv;
    assign o_wb_req = st_r.wb_req;
    assign o_wb_addr = st_r.wb_addr;
    assign o_status = st_r.status;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_acc_op(scu_op_t op);
        acc && i_instr.op == op;
    endsequence

    sequence s_flush_acc;
        acc && (i_instr.op == OP_FLI || i_instr.op == OP_FLD ||
                i_instr.op == OP_FLID);
    endsequence

    sequence s_flush_hold;
        o_stall [*8] ##248 o_stall ##1 !o_stall;
    endsequence

    chk_cop_forward: assert property (
        s_acc_op(OP_COPROC) |=> o_cop_fwd && !o_gpr_we && !o_pc_load &&
            $stable(o_status))
        else $error("coprocessor operation not forwarded cleanly");

    chk_branch_taken: assert property (
        acc && (i_instr.op == OP_BC_T || i_instr.op == OP_BC_F) |=>
            o_redirect.taken == ($past(cond_now) ==
                ($past(i_instr.op) == OP_BC_T)))
        else $error("branch decision wrong");

    chk_branch_target: assert property (
        o_redirect.taken |-> o_redirect.target == $past(i_instr.slot_pc) +
            {{14{$past(i_instr.offset[15])}}, $past(i_instr.offset), 2'b00})
        else $error("branch target wrong");

    chk_slot_squash: assert property (
        acc && (i_instr.op == OP_BC_TL) && !cond_now |=>
            o_redirect.squash && !o_redirect.taken)
        else $error("likely branch slot not squashed");

    chk_move_from: assert property (
        s_acc_op(OP_MFC) ##0 (i_instr.rd == `SCU_CR_EPC) |=>
            o_gpr_we && o_gpr_data == $past(st_r.exception_return_pc))
        else $error("control register read wrong");

    chk_exception_return_op_error: assert property (
        s_acc_op(OP_EXCEPTION_RETURN_OP) ##0 (!i_compat_mode &&
            st_r.status[`SCU_ST_ERL]) |=> o_pc_load &&
            o_pc_value == $past(st_r.err_epc) && !o_status[`SCU_ST_ERL])
        else $error("error return wrong");

    chk_illegal_return: assert property (
        acc && ((i_instr.op == OP_EXCEPTION_RETURN_OP && i_compat_mode) ||
            (i_instr.op == OP_RFE && !i_compat_mode)) |=>
            o_resv_exc && !o_pc_load && $stable(o_status))
        else $error("illegal return not refused");

    chk_flush_stall: assert property (
        s_flush_acc |=> s_flush_hold)
        else $error("flush stall length wrong");

    chk_wait_stall: assert property (
        s_acc_op(OP_WAIT) ##1 (!st_r.int_sync[1] && !st_r.nmi_sync[1])
            |-> o_stall ##1 o_stall)
        else $error("wait did not stall");

    chk_stall_hold: assert property (
        o_stall && st_r.phase == PH_FLUSH && !flush_done |=> o_stall)
        else $error("stall dropped early");

endmodule // scu_sysctl_unit

// *** testbench/scu_pipe_model.sv ***
// Purpose: Pipeline side that offers instructions to the system unit
// Assumes: Called just after a rising clock edge
// Notes: Released fields show inverted data, never the last value
module scu_pipe_model
    import scu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_stall,
    output logic o_valid,
    output scu_instr_t o_instr
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_valid = 1'b0;
        o_instr = '0;
    end

    // Idle edge, hold back while stalled, offer for one edge, release
    task automatic issue(input scu_instr_t ins);
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        while (i_stall !== 1'b0 && n < 2000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        o_valid = 1'b1;
        o_instr = ins;
        @(posedge i_clk);
        #1;
        o_valid = 1'b0;
        o_instr = scu_instr_t'(~ins);
    endtask
endmodule // scu_pipe_model

// *** testbench/scu_sysctl_unit_test.sv ***
// Purpose: Self-checking bench of the system unit
// Assumes: Default parameters, flush stall of 256 cycles
// Notes: Inputs change 1 ns after the rising edge
`include "scu_map.svh"

module scu_sysctl_unit_test
    import scu_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_cop_cond = 4'h0;
    logic i_compat_mode = 1'b0;
    logic i_hw_int = 1'b0;
    logic i_nmi = 1'b0;
    logic valid, stall, pc_load, cop_fwd, gpr_we, resv, ici, dci, wb_req;
    scu_instr_t instr;
    scu_redirect_t redir;
    logic [31:0] pc_value, gpr_data, wb_addr, status;
    logic [1:0] cop_sel;
    logic [24:0] cop_fun;
    int num_errors = 0;
    int checks = 0;

    always #5 i_clk = ~i_clk;

    scu_pipe_model pipe (.i_clk(i_clk), .i_stall(stall), .o_valid(valid),
        .o_instr(instr));

    scu_sysctl_unit uut (.i_clk(i_clk), .i_rst(i_rst), .i_valid(valid),
        .i_instr(instr), .i_cop_cond(i_cop_cond),
        .i_compat_mode(i_compat_mode), .i_hw_int(i_hw_int), .i_nmi(i_nmi),
        .o_stall(stall), .o_redirect(redir), .o_pc_load(pc_load),
        .o_pc_value(pc_value), .o_cop_fwd(cop_fwd), .o_cop_sel(cop_sel),
        .o_cop_fun(cop_fun), .o_gpr_we(gpr_we), .o_gpr_data(gpr_data),
        .o_resv_exc(resv), .o_icache_inv(ici), .o_dcache_inv(dci),
        .o_wb_req(wb_req), .o_wb_addr(wb_addr), .o_status(status));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic scu_instr_t mk(scu_op_t op, logic [4:0] rd,
                                      logic [31:0] d);
        scu_instr_t s;
        s = '0;
        s.op = op;
        s.rd = rd;
        s.rt_data = d;
        s.offset = d[15:0];
        s.cofun = d[24:0];
        s.cop_sel = 2'h1;
        s.slot_pc = 32'h00000400;
        s.base_data = 32'h00001000;
        return s;
    endfunction

    task automatic mtc(input logic [4:0] rd, input logic [31:0] v);
        pipe.issue(mk(OP_MTC, rd, v));
    endtask

    task automatic mfc(input logic [4:0] rd, input logic [31:0] exp);
        pipe.issue(mk(OP_MFC, rd, 32'h0));
        chk(gpr_we === 1'b1 ? gpr_data : ~exp, exp);
    endtask

    task automatic final_report();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_coproc();
        pipe.issue(mk(OP_COPROC, 5'h00, 32'h01ABCDEF));
        chk({cop_fwd, cop_sel, cop_fun, gpr_we}, {1'b1, 2'h1, 25'h1ABCDEF,
            1'b0});
    endtask

    task automatic t_branch();
        scu_op_t ops [4] = '{OP_BC_T, OP_BC_TL, OP_BC_F, OP_BC_FL};
        logic tk;
        for (int k = 0; k < 8; k++) begin
            i_cop_cond = (k >= 4) ? 4'h2 : 4'hD;
            tk = (k >= 4) ^ (k % 4 >= 2);
            pipe.issue(mk(ops[k%4], 5'h00, 32'h0000FFFE));
            chk({redir.taken, redir.squash}, {tk, !tk && k[0]});
            if (tk) begin
                chk(redir.target, 32'h000003F8);
            end
        end
    endtask

    task automatic t_tlb();
        mtc(`SCU_CR_INDEX, 32'h3);
        mtc(`SCU_CR_ENTRY_HI, 32'hA5A50001);
        mtc(`SCU_CR_ENTRY_LO, 32'h5A5A0002);
        pipe.issue(mk(OP_TRANSLATION_WRITE_INDEXED, 5'h00, 32'h0));
        mtc(`SCU_CR_ENTRY_HI, 32'h0);
        mtc(`SCU_CR_ENTRY_LO, 32'h0);
        pipe.issue(mk(OP_TRANSLATION_READ_INDEXED, 5'h00, 32'h0));
        mfc(`SCU_CR_ENTRY_HI, 32'hA5A50001);
        mfc(`SCU_CR_ENTRY_LO, 32'h5A5A0002);
        mtc(`SCU_CR_INDEX, 32'h0);
        pipe.issue(mk(OP_TRANSLATION_PROBE, 5'h00, 32'h0));
        mfc(`SCU_CR_INDEX, 32'h3);
        mtc(`SCU_CR_ENTRY_HI, 32'hC3C30007);
        pipe.issue(mk(OP_TRANSLATION_PROBE, 5'h00, 32'h0));
        mfc(`SCU_CR_INDEX, 32'h80000003);
        pipe.issue(mk(OP_TRANSLATION_WRITE_RANDOM, 5'h00, 32'h0));
        pipe.issue(mk(OP_TRANSLATION_PROBE, 5'h00, 32'h0));
        pipe.issue(mk(OP_MFC, `SCU_CR_INDEX, 32'h0));
        chk({31'h0, gpr_data[31]}, 32'h0);
        mtc(`SCU_CR_ENTRY_HI, 32'h0);
        pipe.issue(mk(OP_TRANSLATION_READ_INDEXED, 5'h00, 32'h0));
        mfc(`SCU_CR_ENTRY_HI, 32'hC3C30007);
    endtask

    task automatic t_return();
        mtc(`SCU_CR_ERR_EPC, 32'h00008000);
        mtc(`SCU_CR_EPC, 32'h00009000);
        mtc(`SCU_CR_STATUS, 32'h6);
        chk(status, 32'h6);
        mfc(`SCU_CR_EPC, 32'h00009000);
        pipe.issue(mk(OP_EXCEPTION_RETURN_OP, 5'h00, 32'h0));
        chk({pc_load, pc_value, status}, {1'b1, 32'h8000, 32'h2});
        pipe.issue(mk(OP_EXCEPTION_RETURN_OP, 5'h00, 32'h0));
        chk({pc_load, pc_value, status}, {1'b1, 32'h9000, 32'h0});
        pipe.issue(mk(OP_RFE, 5'h00, 32'h0));
        chk({resv, pc_load, status}, {2'h2, 32'h0});
        i_compat_mode = 1'b1;
        mtc(`SCU_CR_STATUS, 32'h3C);
        pipe.issue(mk(OP_RFE, 5'h00, 32'h0));
        chk({resv, status}, {1'b0, 32'h3F});
        pipe.issue(mk(OP_EXCEPTION_RETURN_OP, 5'h00, 32'h0));
        chk({resv, pc_load, status}, {2'h2, 32'h3F});
        i_compat_mode = 1'b0;
    endtask

    task automatic t_flush();
        scu_op_t ops [3] = '{OP_FLI, OP_FLD, OP_FLID};
        int n;
        for (int k = 0; k < 3; k++) begin
            pipe.issue(mk(ops[k], 5'h00, 32'h0));
            chk({ici, dci}, {k != 1, k != 0});
            n = 0;
            while (stall === 1'b1 && n < 400) begin
                @(posedge i_clk);
                #1;
                n++;
            end
            chk(n, 256);
        end
    endtask

    task automatic t_wait(input logic nmi);
        int n;
        pipe.issue(mk(OP_WAIT, 5'h00, 32'h0));
        repeat (20) @(posedge i_clk);
        #1;
        chk(stall, 1'b1);
        i_hw_int = !nmi;
        i_nmi = nmi;
        n = 0;
        while (stall === 1'b1 && n < 8) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk({stall, n <= 4}, 2'h1);
        i_hw_int = 1'b0;
        i_nmi = 1'b0;
    endtask

    task automatic t_wb();
        pipe.issue(mk(OP_WB, 5'h00, 32'h0000FFF0));
        chk({wb_req, wb_addr}, {1'b1, 32'h00000FF0});
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk({stall, status}, 33'h0);
        t_coproc();
        t_branch();
        t_tlb();
        t_return();
        t_flush();
        t_wait(1'b0);
        t_wait(1'b1);
        t_wb();
        final_report();
    end

    initial begin
        #200us;
        num_errors++;
        final_report();
    end
endmodule // scu_sysctl_unit_test
